// ---- radio_pm_pkg.sv ----
// Constants and types shared by the radio power and mode controller.
package radio_pm_pkg;

  // ==========================================================
  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned MS_TIME_NS = 1000000;
  localparam int unsigned CYCLES_PER_MS = MS_TIME_NS / CLK_PERIOD_NS;

  // ==========================================================
  // Millisecond timing figures
  localparam int MS_W = 16;
  localparam logic [MS_W-1:0] SAFE_TOGGLE_MS = 16'd250;
  localparam logic [MS_W-1:0] SAFE_REBOOT_MS = 16'd5000;
  localparam logic [MS_W-1:0] WAKE_RESP_MS = 16'd30;
  localparam logic [MS_W-1:0] MARGIN_BASE_MS = 16'd60;
  localparam logic [MS_W-1:0] OVERLAP_EXTRA_MS = 16'd100;
  localparam int MARGIN_SHIFT = 3;
  localparam logic [MS_W-1:0] MS_ZERO = 16'h0000;
  localparam logic [MS_W-1:0] MS_ONE = 16'h0001;
  localparam logic [MS_W-1:0] MS_MAX = 16'hffff;

  // ==========================================================
  // Power save study counts
  localparam logic [2:0] STUDY_PACKETS = 3'd4;
  localparam logic [6:0] CYCLES_PER_STUDY = 7'd100;

  // ==========================================================
  // Bands and reported power state
  localparam int NUM_BANDS = 3;
  localparam logic [2:0] BAND_RESET = 3'h1;
  localparam logic [1:0] PWR_ON = 2'h0;
  localparam logic [1:0] PWR_OFF = 2'h1;
  localparam logic [1:0] PWR_LIGHT_SLEEP = 2'h2;
  localparam logic [1:0] PWR_SAVE = 2'h3;

  // ==========================================================
  // Controller states
  typedef enum logic [2:0] {
    ST_OFF,
    ST_ON,
    ST_LIGHT_SLEEP,
    ST_WAKE,
    ST_PS_SLEEP,
    ST_SAFE,
    ST_REBOOT
  } pm_state_t;

endpackage : radio_pm_pkg

// ---- ps_calc_if.sv ----
// Interface between the controller and its power save timing calculator.
`timescale 1ns/10ps
`default_nettype none
interface ps_calc_if;
  import radio_pm_pkg::*;
  logic [MS_W-1:0] tmin;
  logic [MS_W-1:0] ttx;
  logic [MS_W-1:0] margin;
  logic [MS_W+1:0] sleep_ms;
  logic sleep_positive;
  logic [MS_W+1:0] slot_min;
  logic [MS_W+1:0] slot_max;

  // ==========================================================
  // Controller side and calculator side
  modport ctrl (output tmin, output ttx, input margin, input sleep_ms, input sleep_positive,
                input slot_min, input slot_max);
  modport calc (input tmin, input ttx, output margin, output sleep_ms, output sleep_positive,
                output slot_min, output slot_max);
endinterface : ps_calc_if
`default_nettype wire

// ---- ms_tick_gen.sv ----
// Divider that makes a one-cycle pulse once per millisecond.
`timescale 1ns/10ps
`default_nettype none
module ms_tick_gen #(
  parameter int unsigned DIV = 200000
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Tick out
  output logic tick
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] count;

  // ==========================================================
  // Free running divider
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count == LAST) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule : ms_tick_gen
`default_nettype wire

// ---- ps_timing.sv ----
// Power save margin, sleep period and receive window arithmetic.
`timescale 1ns/10ps
`default_nettype none
module ps_timing
  import radio_pm_pkg::*;
(
  // Calculator side of the timing link
  ps_calc_if.calc pc
);
  logic [MS_W+1:0] tmin_x;
  logic [MS_W+1:0] margin_x;
  logic [MS_W+1:0] ttx_x;
  logic [MS_W+1:0] sleep_x;

  // ==========================================================
  // Extended arithmetic, two spare bits keep the sign of the sleep period
  always_comb begin
    tmin_x = {2'b00, pc.tmin};
    ttx_x = {2'b00, pc.ttx};
    margin_x = {2'b00, (pc.tmin >> MARGIN_SHIFT)} + {2'b00, MARGIN_BASE_MS};
    sleep_x = tmin_x - margin_x - ttx_x;
  end

  assign pc.margin = margin_x[MS_W-1:0];
  assign pc.sleep_ms = sleep_x;
  // Top bit set means the difference went negative
  assign pc.sleep_positive = !sleep_x[MS_W+1] && (sleep_x != '0);
  assign pc.slot_min = tmin_x - margin_x;
  assign pc.slot_max = tmin_x + margin_x + {2'b00, OVERLAP_EXTRA_MS};
endmodule : ps_timing
`default_nettype wire

// ---- radio_power_mode_control.sv ----
// Mode and power state controller of the radio transceiver module.
`timescale 1ns/10ps
`default_nettype none
module radio_power_mode_control
  import radio_pm_pkg::*;
#(
  parameter int unsigned CYCLES_MS = CYCLES_PER_MS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Module pins
  input wire logic module_enable_line,
  input wire logic port1_transmit_data_input,
  output logic status_indicator_pin,
  // Firmware events
  input wire logic fault_detect,
  input wire logic restart_cmd,
  input wire logic sleep_cmd,
  input wire logic power_save_enable,
  input wire logic rx_packet_ok,
  input wire logic [MS_W-1:0] tx_time_ms,
  // Band selection and configuration writes
  input wire logic band_select_valid,
  input wire logic [1:0] band_select_idx,
  input wire logic config_write,
  output logic [NUM_BANDS-1:0] active_band,
  output logic [NUM_BANDS-1:0] band_config_write,
  // Power and radio controls
  output logic radio_power_on,
  output logic radio_enable,
  output logic uart_power_on,
  output logic settings_reset,
  output logic cpu_reboot,
  output logic ok_response,
  output logic [1:0] power_state,
  output logic ps_study_done
);
  pm_state_t state;
  pm_state_t next_state;
  logic ms_tick;
  logic [MS_W-1:0] phase_ms;
  logic [MS_W-1:0] blink_ms;
  logic safe_blink;
  logic td_prev;
  logic td_change;
  logic [2:0] pkt_count;
  logic [MS_W-1:0] tmin;
  logic [MS_W-1:0] ms_since;
  logic [6:0] cycle_count;
  logic pkt_seen;
  logic ps_go_sleep;
  logic window_lost;
  logic study_clear;
  logic pkt_accept;
  ps_calc_if pc ();

  // ==========================================================
  // Time base and power save arithmetic
  ms_tick_gen #(
    .DIV(CYCLES_MS)
  ) u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick(ms_tick)
  );

  assign pc.tmin = tmin;
  assign pc.ttx = tx_time_ms;

  ps_timing u_calc (
    .pc(pc)
  );

  // ==========================================================
  // Wake detection on the serial input
  // Inputs are synchronous, so any sampled change counts as a wake event
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      td_prev <= 1'b1;
    end else begin
      td_prev <= port1_transmit_data_input;
    end
  end

  assign td_change = (td_prev != port1_transmit_data_input);

  // ==========================================================
  // Power save decisions
  // Sleep is decided one cycle after the packet so the fresh minimum is used
  assign ps_go_sleep = pkt_seen && power_save_enable && ps_study_done
                       && pc.sleep_positive;
  assign window_lost = ps_study_done && power_save_enable && (state == ST_ON)
                       && ({2'b00, ms_since} > pc.slot_max);
  assign pkt_accept = rx_packet_ok && radio_enable && power_save_enable;
  assign study_clear = !power_save_enable || (state == ST_OFF) || (state == ST_REBOOT)
                       || (state == ST_SAFE) || window_lost;

  // ==========================================================
  // Next state
  always_comb begin
    next_state = state;
    if (!module_enable_line) begin
      next_state = ST_OFF;
    end else begin
      unique case (state)
        ST_OFF: begin
          next_state = ST_ON;
        end
        ST_ON: begin
          if (fault_detect) begin
            next_state = ST_SAFE;
          end else if (restart_cmd) begin
            next_state = ST_REBOOT;
          end else if (sleep_cmd) begin
            next_state = ST_LIGHT_SLEEP;
          end else if (ps_go_sleep) begin
            next_state = ST_PS_SLEEP;
          end
        end
        ST_LIGHT_SLEEP: begin
          if (fault_detect) begin
            next_state = ST_SAFE;
          end else if (td_change) begin
            next_state = ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (phase_ms >= WAKE_RESP_MS) begin
            next_state = ST_ON;
          end
        end
        ST_PS_SLEEP: begin
          if (fault_detect) begin
            next_state = ST_SAFE;
          end else if (restart_cmd) begin
            next_state = ST_REBOOT;
          end else if (!power_save_enable || ({2'b00, ms_since} >= pc.sleep_ms)) begin
            next_state = ST_ON;
          end
        end
        ST_SAFE: begin
          if (phase_ms >= SAFE_REBOOT_MS) begin
            next_state = ST_REBOOT;
          end
        end
        ST_REBOOT: begin
          next_state = ST_ON;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Time spent in the current state, in milliseconds
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase_ms <= MS_ZERO;
    end else if (next_state != state) begin
      phase_ms <= MS_ZERO;
    end else if (ms_tick && (phase_ms != MS_MAX)) begin
      phase_ms <= phase_ms + MS_ONE;
    end
  end

  // ==========================================================
  // Safe mode blink
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      blink_ms <= MS_ZERO;
      safe_blink <= 1'b0;
    end else if (state != ST_SAFE) begin
      blink_ms <= MS_ZERO;
      safe_blink <= 1'b0;
    end else if (ms_tick) begin
      if (blink_ms == SAFE_TOGGLE_MS - MS_ONE) begin
        blink_ms <= MS_ZERO;
        safe_blink <= !safe_blink;
      end else begin
        blink_ms <= blink_ms + MS_ONE;
      end
    end
  end

  // ==========================================================
  // Interval study: packet count, minimum interval, time since last packet
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pkt_count <= 3'd0;
      tmin <= MS_MAX;
      ms_since <= MS_ZERO;
      ps_study_done <= 1'b0;
      pkt_seen <= 1'b0;
    end else if (study_clear) begin
      pkt_count <= 3'd0;
      tmin <= MS_MAX;
      ms_since <= MS_ZERO;
      ps_study_done <= 1'b0;
      pkt_seen <= 1'b0;
    end else if (pkt_accept && (cycle_count == CYCLES_PER_STUDY)) begin
      // Restart keeps this packet as the first one of the new study
      pkt_count <= 3'd1;
      tmin <= MS_MAX;
      ms_since <= MS_ZERO;
      ps_study_done <= 1'b0;
      pkt_seen <= 1'b0;
    end else if (pkt_accept) begin
      pkt_seen <= 1'b1;
      ms_since <= MS_ZERO;
      if (pkt_count != 3'd0 && ms_since < tmin) begin
        tmin <= ms_since;
      end
      if (pkt_count != STUDY_PACKETS) begin
        pkt_count <= pkt_count + 3'd1;
      end
      if (pkt_count == STUDY_PACKETS - 3'd1) begin
        ps_study_done <= 1'b1;
      end
    end else begin
      pkt_seen <= 1'b0;
      if (ms_tick && (pkt_count != 3'd0) && (ms_since != MS_MAX)) begin
        ms_since <= ms_since + MS_ONE;
      end
    end
  end

  // ==========================================================
  // Completed sleep and wake cycles since the study finished
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cycle_count <= 7'd0;
    end else if (study_clear || !ps_study_done) begin
      cycle_count <= 7'd0;
    end else if (pkt_accept && (cycle_count == CYCLES_PER_STUDY)) begin
      cycle_count <= 7'd0;
    end else if ((state == ST_PS_SLEEP) && (next_state == ST_ON)) begin
      cycle_count <= cycle_count + 7'd1;
    end
  end

  // ==========================================================
  // Band selection; the band is a stored setting and survives off and reboot
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      active_band <= BAND_RESET;
    end else if (band_select_valid && (state == ST_ON)
                 && (band_select_idx < 2'(NUM_BANDS))) begin
      active_band <= NUM_BANDS'(1) << band_select_idx;
    end
  end

  // Writes are steered to the active band alone
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      band_config_write <= '0;
    end else begin
      band_config_write <= active_band & {NUM_BANDS{config_write && (state == ST_ON)}};
    end
  end

  // ==========================================================
  // Registered power, radio and indicator outputs
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      radio_power_on <= 1'b0;
      radio_enable <= 1'b0;
      uart_power_on <= 1'b0;
      settings_reset <= 1'b1;
      status_indicator_pin <= 1'b0;
      power_state <= PWR_OFF;
    end else begin
      radio_power_on <= (next_state == ST_ON) || (next_state == ST_SAFE);
      // Radio traffic only while fully on; safe mode blocks it
      radio_enable <= (next_state == ST_ON);
      uart_power_on <= (next_state != ST_OFF) && (next_state != ST_REBOOT);
      settings_reset <= (next_state == ST_OFF);
      unique case (next_state)
        ST_OFF: begin
          status_indicator_pin <= 1'b0;
          power_state <= PWR_OFF;
        end
        ST_LIGHT_SLEEP, ST_WAKE: begin
          status_indicator_pin <= 1'b0;
          power_state <= PWR_LIGHT_SLEEP;
        end
        ST_PS_SLEEP: begin
          status_indicator_pin <= 1'b1;
          power_state <= PWR_SAVE;
        end
        ST_SAFE: begin
          status_indicator_pin <= safe_blink;
          power_state <= PWR_ON;
        end
        default: begin
          status_indicator_pin <= 1'b1;
          power_state <= PWR_ON;
        end
      endcase
    end
  end

  // ==========================================================
  // One-cycle event outputs
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ok_response <= 1'b0;
      cpu_reboot <= 1'b0;
    end else begin
      ok_response <= (state == ST_WAKE) && (next_state == ST_ON);
      cpu_reboot <= (next_state == ST_REBOOT) && (state != ST_REBOOT);
    end
  end

endmodule : radio_power_mode_control
`default_nettype wire

// ---- radio_pm_checker.sv ----
// Port-level checks on the radio power and mode controller.
`timescale 1ns/10ps
`default_nettype none
module radio_pm_checker
  import radio_pm_pkg::*;
#(
  parameter int unsigned CYCLES_MS = CYCLES_PER_MS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Pins and events
  input wire logic module_enable_line,
  input wire logic status_indicator_pin,
  input wire logic fault_detect,
  input wire logic restart_cmd,
  input wire logic sleep_cmd,
  input wire logic config_write,
  input wire logic [NUM_BANDS-1:0] active_band,
  input wire logic [NUM_BANDS-1:0] band_config_write,
  // Power outputs
  input wire logic radio_power_on,
  input wire logic radio_enable,
  input wire logic uart_power_on,
  input wire logic settings_reset,
  input wire logic cpu_reboot,
  input wire logic ok_response,
  input wire logic [1:0] power_state,
  input wire logic ps_study_done
);
  localparam int unsigned SAFE_MAX = (SAFE_REBOOT_MS + 1) * CYCLES_MS + 4;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Safe mode is the only state with the radio powered but not enabled
  logic safe;
  int unsigned safe_cyc;
  assign safe = radio_power_on && !radio_enable;
  // Bounds the stay in safe mode; a stuck reboot timer shows here
  always_ff @(posedge core_clk) begin
    if (!rst_n || !safe) begin
      safe_cyc <= 0;
    end else begin
      safe_cyc <= safe_cyc + 1;
    end
  end

  // ==========================================================
  // Sequences
  sequence s_fault;
    radio_enable && module_enable_line && fault_detect;
  endsequence
  sequence s_restart;
    radio_enable && module_enable_line && restart_cmd && !fault_detect;
  endsequence
  sequence s_sleep;
    radio_enable && module_enable_line && sleep_cmd && !fault_detect && !restart_cmd;
  endsequence
  sequence s_reboot_then_on;
    cpu_reboot && !uart_power_on ##1 !cpu_reboot && radio_enable;
  endsequence

  // ==========================================================
  // Properties
  property p_band_onehot;
    $onehot(active_band);
  endproperty
  property p_cfg_route;
    config_write && radio_enable && module_enable_line |=> band_config_write == $past(active_band);
  endproperty
  property p_cfg_quiet;
    !config_write |=> band_config_write == '0;
  endproperty
  property p_off;
    !module_enable_line [*2] |-> ##1 (settings_reset && power_state == PWR_OFF && !uart_power_on);
  endproperty
  property p_fault_quiet;
    s_fault |=> !radio_enable [*8];
  endproperty
  property p_safe_len;
    safe_cyc <= SAFE_MAX;
  endproperty
  property p_sleep;
    s_sleep |=> power_state == PWR_LIGHT_SLEEP && !radio_power_on && uart_power_on;
  endproperty
  property p_sleep_dark;
    power_state == PWR_LIGHT_SLEEP |-> !status_indicator_pin && !radio_enable;
  endproperty
  property p_ok;
    ok_response |-> radio_enable && power_state == PWR_ON && $past(power_state) == PWR_LIGHT_SLEEP;
  endproperty
  property p_restart;
    s_restart |=> s_reboot_then_on;
  endproperty
  property p_ps_sleep;
    power_state == PWR_SAVE |-> ps_study_done && !radio_power_on;
  endproperty

  a_band_onehot: assert property (p_band_onehot) else $error("band not one-hot");
  a_cfg_route: assert property (p_cfg_route) else $error("config write misrouted");
  a_cfg_quiet: assert property (p_cfg_quiet) else $error("stray config write");
  a_off: assert property (p_off) else $error("enable low not off");
  a_fault_quiet: assert property (p_fault_quiet) else $error("radio live in safe");
  a_safe_len: assert property (p_safe_len) else $error("safe mode too long");
  a_sleep: assert property (p_sleep) else $error("light sleep outputs");
  a_sleep_dark: assert property (p_sleep_dark) else $error("indicator lit asleep");
  a_ok: assert property (p_ok) else $error("ok outside wake");
  a_restart: assert property (p_restart) else $error("restart sequence");
  a_ps_sleep: assert property (p_ps_sleep) else $error("power save sleep");
endmodule : radio_pm_checker

bind radio_power_mode_control radio_pm_checker #(.CYCLES_MS(CYCLES_MS)) u_chk (.core_clk,
  .rst_n, .module_enable_line, .status_indicator_pin, .fault_detect, .restart_cmd, .sleep_cmd,
  .config_write, .active_band, .band_config_write, .radio_power_on, .radio_enable,
  .uart_power_on, .settings_reset, .cpu_reboot, .ok_response, .power_state, .ps_study_done);
`default_nettype wire

// ---- host_terminal.sv ----
// Host terminal model: drives the enable line and the port 1 transmit line.
`timescale 1ns/10ps
`default_nettype none
module host_terminal #(
  parameter int BIT_CYC = 4,
  parameter int PULSE_CYC = 40
) (
  // Clock
  input wire logic core_clk,
  // Device side
  input wire logic ok_response,
  output logic module_enable_line,
  output logic port1_transmit_data_input
);
  // Serial line idles high; power starts off
  initial begin
    module_enable_line = 1'b0;
    port1_transmit_data_input = 1'b1;
  end
  task automatic set_enable(input logic en);
    @(posedge core_clk);
    #1 module_enable_line = en;
  endtask : set_enable
  // Pulse width scaled down with the millisecond base
  task automatic wake_pulse();
    @(posedge core_clk);
    #1 port1_transmit_data_input = 1'b0;
    repeat (PULSE_CYC) @(posedge core_clk);
    #1 port1_transmit_data_input = 1'b1;
  endtask : wake_pulse
  // Start bit, data low bit first, stop bit
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk);
      #1 port1_transmit_data_input = frame[i];
      repeat (BIT_CYC - 1) @(posedge core_clk);
    end
  endtask : send_byte
  // No traffic until the device reports it is awake
  task automatic wait_ok(input int lim, output int n);
    n = 0;
    while (ok_response !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask : wait_ok
endmodule : host_terminal
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the radio power and mode controller.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import radio_pm_pkg::*;
  localparam int CM = 4; // Millisecond in cycles, shortened for run time
  logic core_clk, rst_n, fault_detect, restart_cmd, sleep_cmd, power_save_enable;
  logic rx_packet_ok, band_select_valid, config_write, status_indicator_pin, ok_response;
  logic module_enable_line, port1_transmit_data_input, radio_power_on, radio_enable;
  logic uart_power_on, settings_reset, cpu_reboot, ps_study_done, prev, ok;
  logic [MS_W-1:0] tx_time_ms;
  logic [1:0] band_select_idx, power_state;
  logic [2:0] active_band, band_config_write, exp_band;
  logic [15:0] rng = 16'hcb3a;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  int r, n, d, ps, cnt, tmin, marg, exp_sleep, last;

  radio_power_mode_control #(.CYCLES_MS(CM)) DUT (.core_clk, .rst_n, .module_enable_line,
    .port1_transmit_data_input, .status_indicator_pin, .fault_detect, .restart_cmd, .sleep_cmd,
    .power_save_enable, .rx_packet_ok, .tx_time_ms, .band_select_valid, .band_select_idx,
    .config_write, .active_band, .band_config_write, .radio_power_on, .radio_enable,
    .uart_power_on, .settings_reset, .cpu_reboot, .ok_response, .power_state, .ps_study_done);
  host_terminal host (.core_clk, .ok_response, .module_enable_line, .port1_transmit_data_input);

  // ==========================================================
  // Helpers
  function automatic int rnd();
    rng = {rng[14:0], rng[15] ^ rng[13] ^ rng[12] ^ rng[10]};
    return int'(rng);
  endfunction : rnd
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic check(input bit good, input string what);
    n_tests++;
    if (!good) begin
      error_cnt++;
      $display("mismatch %0t %s", $time, what);
    end
  endtask : check
  task automatic complete_run();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Hang guard, well above the expected run length
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    {fault_detect, restart_cmd, sleep_cmd, power_save_enable, rx_packet_ok} = '0;
    {band_select_valid, band_select_idx, config_write} = '0;
    tx_time_ms = 16'h0032;
    rst_n = 1'b0;
    tick(20);
    check(settings_reset === 1'b1 && power_state === PWR_OFF, "reset off");
    check(active_band === BAND_RESET, "reset band");
    rst_n = 1'b1;
    host.set_enable(1'b1);
    tick(4);
    check(radio_enable === 1'b1 && power_state === PWR_ON, "power on");
    // Band selects, reserved index first, then random ones
    exp_band = BAND_RESET;
    for (int i = 0; i < 8; i++) begin
      r = (i < 4) ? 3 - i : rnd() % 4;
      band_select_idx = r[1:0];
      band_select_valid = 1'b1;
      tick(1);
      band_select_valid = 1'b0;
      config_write = 1'b1;
      if (r < 3) exp_band = 3'h1 << r;
      tick(1);
      config_write = 1'b0;
      check(active_band === exp_band && band_config_write === exp_band, "band");
    end
    // Light sleep, woken once by a pulse and once by a zero byte
    for (int k = 0; k < 2; k++) begin
      sleep_cmd = 1'b1;
      tick(1);
      sleep_cmd = 1'b0;
      tick(2 * CM);
      check(power_state === PWR_LIGHT_SLEEP && uart_power_on === 1'b1
            && radio_power_on === 1'b0, "sleep");
      fork
        if (k == 0) host.wake_pulse(); else host.send_byte(8'h00);
        host.wait_ok(40 * CM, n);
      join
      check(n >= 29 * CM && n <= 32 * CM && radio_enable === 1'b1, "wake");
      tick(10 * CM);
      check(power_state === PWR_ON, "stays on");
    end
    // Interval study, self-timed sleeps, then a sleep period that goes negative
    power_save_enable = 1'b1;
    cnt = 0;
    tmin = 65535;
    exp_sleep = 0;
    for (int p = 0; p < 8; p++) begin
      d = 300 + rnd() % 64;
      ps = 0;
      repeat (d * CM - 1) begin
        tick(1);
        if (power_state === PWR_SAVE) ps++;
      end
      ok = (ps >= (exp_sleep - 2) * CM && ps <= (exp_sleep + 2) * CM) || (ps == 0 && cnt == 4);
      if (exp_sleep > 0) begin
        check(ok, "ps sleep");
      end else begin
        check(ps == 0, "no sleep");
      end
      rx_packet_ok = 1'b1;
      tick(1);
      rx_packet_ok = 1'b0;
      // Longer message from here on; it must be set before the sleep decision cycle
      if (p == 5) tx_time_ms = 16'h0190;
      if (cnt > 0 && d < tmin) tmin = d;
      cnt++;
      marg = tmin / 8 + 60;
      exp_sleep = (cnt >= 4) ? tmin - marg - int'(tx_time_ms) : 0;
      check(ps_study_done === (cnt >= 4), "study");
    end
    // Missed receive window drops the study
    tick((tmin + marg + 104) * CM);
    check(ps_study_done === 1'b0, "lost packet");
    restart_cmd = 1'b1;
    tick(1);
    restart_cmd = 1'b0;
    check(cpu_reboot === 1'b1 && uart_power_on === 1'b0, "restart");
    tick(2);
    check(radio_enable === 1'b1, "back on");
    // Band chosen earlier is a stored setting, so it survives the reboot
    check(active_band === exp_band, "band kept");
    // Fault: fixed blink period, then a reboot
    fault_detect = 1'b1;
    tick(1);
    fault_detect = 1'b0;
    check(radio_enable === 1'b0 && radio_power_on === 1'b1, "safe radio");
    n = 0;
    last = 0;
    while (cpu_reboot !== 1'b1 && n < 5002 * CM) begin
      prev = status_indicator_pin;
      tick(1);
      n++;
      if (status_indicator_pin !== prev && cpu_reboot !== 1'b1) begin
        ok = (last > 0) ? n - last == 250 * CM : n >= 249 * CM && n <= 251 * CM;
        check(ok, "blink");
        last = n;
      end
    end
    check(n >= 4999 * CM && n <= 5001 * CM + 2, "reboot time");
    // Enable low turns everything off
    host.set_enable(1'b0);
    tick(3);
    check(settings_reset === 1'b1 && power_state === PWR_OFF && uart_power_on === 1'b0, "off");
    host.set_enable(1'b1);
    tick(4);
    check(power_state === PWR_ON && ps_study_done === 1'b0, "on again");
    complete_run();
  end
endmodule : tb
`default_nettype wire
